/* bench/otrc_bench.sv */
// Register-level bench for the trim and reference control block
`timescale 1ns/10ps
module otrc_bench;
    import otrc_pkg::*;
    logic              mclk_in = 1'b0;
    logic              reset_in = 1'b1;
    logic [ADDR_W-1:0] adr = 4'h0;
    logic              rd = 1'b0;
    logic              wr = 1'b0;
    logic [DATA_W-1:0] wdat = 32'h0;
    logic [3:0]        be = 4'h0;
    logic              stable = 1'b0;
    logic [DATA_W-1:0] rdat;
    logic [DATA_W-1:0] q;
    logic              ce = 1'b1;
    logic [DATA_W-1:0] rdat2;
    logic [DATA_W-1:0] q2;
    logic              wreq;
    logic [TRIM_W-1:0] trim;
    logic              en;
    logic [GAIN_W-1:0] gain;
    logic [2:0]        lvl;
    logic [31:0]       tv [3] = '{32'hffffffe0, 32'h0000001f, 32'h000000ff};
    int                n_mismatch = 0;
    int                total_checks = 0;
    otrc_top u_otrc_top (.mclk_in(mclk_in), .reset_in(reset_in), .clk_en_in(ce),
        .avs_address_in(adr), .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdat),
        .avs_byteenable_in(be), .avs_readdata_out(rdat), .avs_waitrequest_out(wreq),
        .ref_stable_in(stable), .oscillator_trim_out(trim), .reference_enable_out(en),
        .reference_gain_select_out(gain), .reference_level_out(lvl));
    // Standard-voltage variant on the same bus
    otrc_top #(.STANDARD_VOLTAGE(1'b1)) u_otrc_top_std (.mclk_in(mclk_in), .reset_in(reset_in),
        .clk_en_in(ce), .avs_address_in(adr), .avs_read_in(rd), .avs_write_in(wr),
        .avs_writedata_in(wdat), .avs_byteenable_in(be), .avs_readdata_out(rdat2),
        .avs_waitrequest_out(), .ref_stable_in(stable), .oscillator_trim_out(),
        .reference_enable_out(), .reference_gain_select_out(), .reference_level_out());
    initial
    begin
        forever #2 mclk_in = ~mclk_in;
    end
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // One bus cycle, held until wait is sampled low
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d, input logic [3:0] b);
        int i;
        @(posedge mclk_in);
        adr <= a;
        wr <= w;
        rd <= !w;
        wdat <= d;
        be <= b;
        for (i = 0; i < 20; i++)
        begin
            @(posedge mclk_in);
            if (!wreq)
                break;
        end
        q = rdat;
        q2 = rdat2;
        wr <= 1'b0;
        rd <= 1'b0;
        if (i == 20)
        begin
            n_mismatch++;
            report_and_stop();
        end
        @(negedge mclk_in);
    endtask
    initial
    begin
        repeat (6) @(posedge mclk_in);
        reset_in <= 1'b0;
        bus(0, OFS_TRIM, 0, 0); check("trim reset", q, 32'h0);
        bus(0, OFS_REF, 0, 0); check("ref reset", q, 32'h0);
        check("std ready", q2, 32'h80);
        for (int k = 0; k < 3; k++)
        begin
            bus(1, OFS_TRIM, tv[k], 4'hf); check("trim out", trim, tv[k][5:0]);
            bus(0, OFS_TRIM, 0, 0); check("trim read", q, {26'h0, tv[k][5:0]});
        end
        bus(1, OFS_TRIM, 32'h5, 4'he);
        bus(1, 4'h8, 32'h5, 4'hf);
        bus(0, 4'h8, 0, 0); check("unmapped", q, 32'h0);
        check("trim kept", trim, 6'h3f);
        // Clock enable low stalls a write in flight
        fork
            bus(1, OFS_TRIM, 32'h2a, 4'h1);
            begin
                @(posedge mclk_in);
                ce <= 1'b0;
                repeat (5) @(posedge mclk_in);
                ce <= 1'b1;
            end
        join
        check("trim after freeze", trim, 6'h2a);
        $display("trim tests done");
        for (int g = 0; g < 4; g++)
        begin
            bus(1, OFS_REF, 32'hfc | g, 4'h1); check("gain out", {en, gain}, 3'h4 | g);
            bus(0, OFS_REF, 0, 0); check("ref read", q, 32'h40 | g);
            check("level", lvl, g == 0 ? 3'h0 : 3'h1 << (g - 1));
        end
        @(posedge mclk_in);
        stable <= 1'b1;
        repeat (70) @(posedge mclk_in);
        bus(0, OFS_REF, 0, 0); check("ready", q, 32'hc3);
        bus(1, OFS_REF, 32'h1, 4'h1);
        bus(0, OFS_REF, 0, 0); check("ready off", q, 32'h1);
        check("std ready on", q2, 32'h81);
        check("level off", lvl, 3'h0);
        $display("reference tests done");
        report_and_stop();
    end
endmodule

/* bench/otrc_properties.sv */
// Port-level checks of the trim and reference control registers
`timescale 1ns/10ps
module otrc_properties
    import otrc_pkg::*;
#(
    parameter bit STANDARD_VOLTAGE = 1'b0
)
(
    input wire logic                        mclk_in,
    input wire logic                        reset_in,
    input wire logic                        clk_en_in,
    input wire logic [otrc_pkg::ADDR_W-1:0] avs_address_in,
    input wire logic                        avs_read_in,
    input wire logic                        avs_write_in,
    input wire logic [otrc_pkg::DATA_W-1:0] avs_writedata_in,
    input wire logic [3:0]                  avs_byteenable_in,
    input wire logic [otrc_pkg::DATA_W-1:0] avs_readdata_out,
    input wire logic                        avs_waitrequest_out,
    input wire logic [otrc_pkg::TRIM_W-1:0] oscillator_trim_out,
    input wire logic                        reference_enable_out,
    input wire logic [otrc_pkg::GAIN_W-1:0] reference_gain_select_out,
    input wire logic [2:0]                  reference_level_out
);
    default clocking @(posedge mclk_in); endclocking
    default disable iff (reset_in);
    wire rd_ok = avs_read_in && !avs_waitrequest_out;
    wire wr_ok = avs_write_in && !avs_waitrequest_out && avs_byteenable_in[0] && clk_en_in;
    wire tw    = wr_ok && avs_address_in == OFS_TRIM;
    wire rw    = wr_ok && avs_address_in == OFS_REF;
    a_trim_reset: assert property ($fell(reset_in) |-> oscillator_trim_out == 6'h00 && !reference_enable_out) else $error("bad reset value");
    a_trim_write: assert property (tw |=> oscillator_trim_out == $past(avs_writedata_in[5:0])) else $error("trim not applied");
    a_trim_hold: assert property (!tw |=> $stable(oscillator_trim_out)) else $error("trim moved");
    a_trim_read: assert property (rd_ok && avs_address_in == OFS_TRIM |-> avs_readdata_out == {26'h0, oscillator_trim_out}) else $error("trim read wrong");
    a_ref_read: assert property (rd_ok && avs_address_in == OFS_REF |-> avs_readdata_out[31:8] == 24'h0 && avs_readdata_out[5:0] == {4'h0, reference_gain_select_out} && avs_readdata_out[6] == reference_enable_out) else $error("ref read wrong");
    a_ref_write: assert property (rw |=> reference_enable_out == $past(avs_writedata_in[6]) && reference_gain_select_out == $past(avs_writedata_in[1:0])) else $error("ref not applied");
    a_one_wait: assert property (clk_en_in && (avs_read_in || avs_write_in) && avs_waitrequest_out |=> !avs_waitrequest_out) else $error("stalled");
    a_wait_pulse: assert property (!avs_waitrequest_out && clk_en_in |=> avs_waitrequest_out) else $error("wait low too long");
    a_freeze_hold: assert property (!clk_en_in |=> $stable(avs_waitrequest_out) && $stable(oscillator_trim_out)) else $error("moved while frozen");
    a_level_map: assert property ($past(clk_en_in) |-> reference_level_out == ((!$past(reference_enable_out) || $past(reference_gain_select_out) == 2'h0) ? 3'h0 : 3'h1 << ($past(reference_gain_select_out) - 2'h1))) else $error("level wrong");
    a_ready_gate: assert property (!STANDARD_VOLTAGE && rd_ok && avs_address_in == OFS_REF && !reference_enable_out && !$past(reference_enable_out) && !$past(reference_enable_out, 2) && !$past(reference_enable_out, 3) |-> !avs_readdata_out[7]) else $error("ready while off");
endmodule
bind otrc_top otrc_properties #(.STANDARD_VOLTAGE(STANDARD_VOLTAGE)) u_otrc_properties
(
    .mclk_in                   (mclk_in),
    .reset_in                  (reset_in),
    .clk_en_in                 (clk_en_in),
    .avs_address_in            (avs_address_in),
    .avs_read_in               (avs_read_in),
    .avs_write_in              (avs_write_in),
    .avs_writedata_in          (avs_writedata_in),
    .avs_byteenable_in         (avs_byteenable_in),
    .avs_readdata_out          (avs_readdata_out),
    .avs_waitrequest_out       (avs_waitrequest_out),
    .oscillator_trim_out       (oscillator_trim_out),
    .reference_enable_out      (reference_enable_out),
    .reference_gain_select_out (reference_gain_select_out),
    .reference_level_out       (reference_level_out)
);

/* hdl/otrc_gain_decode.sv */
// One-hot decode of the reference gain select
`timescale 1ns/10ps
module otrc_gain_decode
    import otrc_pkg::*;
(
    // Select code
    input  wire logic [otrc_pkg::GAIN_W-1:0] gain_sel_in,
    input  wire logic                        enable_in,
    // One-hot level choice, all low means output off
    output logic      [2:0]                  level_onehot_out
);
    assign level_onehot_out[0] = enable_in && (gain_sel_in == GAIN_X1);
    assign level_onehot_out[1] = enable_in && (gain_sel_in == GAIN_X2);
    assign level_onehot_out[2] = enable_in && (gain_sel_in == GAIN_X4);
endmodule

/* hdl/otrc_pkg.sv */
// Shared constants for the oscillator trim and reference control block
package otrc_pkg;
    localparam int unsigned ADDR_W          = 4;
    localparam int unsigned DATA_W          = 32;
    localparam int unsigned TRIM_W          = 6;
    localparam int unsigned GAIN_W          = 2;
    localparam int unsigned STABLE_CNT_W    = 8;
    // Byte offsets of the registers
    localparam logic [ADDR_W-1:0] OFS_TRIM  = 4'h0;
    localparam logic [ADDR_W-1:0] OFS_REF   = 4'h4;
    // Field positions in the reference control register
    localparam int unsigned REF_READY_BIT   = 7;
    localparam int unsigned REF_ENABLE_BIT  = 6;
    localparam int unsigned REF_GAIN_LSB    = 0;
    // Reset values
    localparam logic [TRIM_W-1:0] TRIM_RESET = 6'h00;
    localparam logic [GAIN_W-1:0] GAIN_RESET = 2'h0;
    localparam logic              EN_RESET   = 1'b0;
    // Gain select codes
    localparam logic [GAIN_W-1:0] GAIN_OFF  = 2'h0;
    localparam logic [GAIN_W-1:0] GAIN_X1   = 2'h1;
    localparam logic [GAIN_W-1:0] GAIN_X2   = 2'h2;
    localparam logic [GAIN_W-1:0] GAIN_X4   = 2'h3;
    // Settling time of the reference before it reports ready
    localparam int unsigned CLK_MHZ         = 250;
    localparam int unsigned SETTLE_NS       = 200;
    localparam logic [STABLE_CNT_W-1:0] SETTLE_CYCLES =
        STABLE_CNT_W'((SETTLE_NS * CLK_MHZ + 999) / 1000);
    localparam logic [STABLE_CNT_W-1:0] CNT_ZERO = 8'h00;
    localparam logic [DATA_W-1:0] RD_UNMAPPED = 32'h00000000;
endpackage

/* hdl/otrc_sync2.sv */
// Two-flip-flop synchroniser for one level from outside the clock domain
`timescale 1ns/10ps
module otrc_sync2
(
    // Clock, reset and enable
    input  wire logic mclk_in,
    input  wire logic reset_in,
    input  wire logic clk_en_in,
    // Level
    input  wire logic level_in,
    output logic      level_out
);
    logic stage1;

    always_ff @(posedge mclk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            stage1    <= 1'b0;
            level_out <= 1'b0;
        end
        else if (clk_en_in)
        begin
            stage1    <= level_in;
            level_out <= stage1;
        end
    end
endmodule

/* hdl/otrc_top.sv */
// Oscillator trim and voltage reference control registers on Avalon-MM
// Function
// - Trim value held as six-bit signed two's complement number.
// - Trim register resets to zero.
// - Trim write applies at once; no stall of the bus. Here every access, trim write included, holds wait high for one cycle.
// - No flag or signal reports that a frequency shift finished.
// - Trim bits 7-6 ignore writes and read zero.
// - Bit 7 of reference control is read-only ready flag.
// - Standard-voltage variants read ready as one always. Here a read sampled on the first enabled edge after reset reads ready as zero.
// - Bit 6 is reference enable, read/write, cleared by reset.
// - Gain select: 00 off, 01 one, 10 two, 11 four times.
//
// The register offsets and the Avalon-MM slave port were left to the implementer.
`timescale 1ns/10ps
module otrc_top
    import otrc_pkg::*;
#(
    parameter bit STANDARD_VOLTAGE = 1'b0
)
(
    // Clock, reset, enable
    input  wire logic                        mclk_in,
    input  wire logic                        reset_in,
    input  wire logic                        clk_en_in,
    // Avalon-MM slave
    input  wire logic [otrc_pkg::ADDR_W-1:0] avs_address_in,
    input  wire logic                        avs_read_in,
    input  wire logic                        avs_write_in,
    input  wire logic [otrc_pkg::DATA_W-1:0] avs_writedata_in,
    input  wire logic [3:0]                  avs_byteenable_in,
    output logic      [otrc_pkg::DATA_W-1:0] avs_readdata_out,
    output logic                             avs_waitrequest_out,
    // Analogue status from the reference
    input  wire logic                        ref_stable_in,
    // Analogue controls
    output logic      [otrc_pkg::TRIM_W-1:0] oscillator_trim_out,
    output logic                             reference_enable_out,
    output logic      [otrc_pkg::GAIN_W-1:0] reference_gain_select_out,
    output logic      [2:0]                  reference_level_out
);
    logic [TRIM_W-1:0]       oscillator_trim;
    logic                    reference_enable;
    logic [GAIN_W-1:0]       reference_gain_select;
    logic [STABLE_CNT_W-1:0] settle_cnt;
    logic                    ref_stable_sync;
    logic                    reference_ready_flag;
    logic                    answered;
    logic [2:0]              level_onehot;

    wire hit_trim  = (avs_address_in == OFS_TRIM);
    wire hit_ref   = (avs_address_in == OFS_REF);
    wire access    = avs_read_in || avs_write_in;
    // One wait cycle, answer on the second edge of each request
    wire take      = access && answered;
    wire wr_lane0  = take && avs_write_in && avs_byteenable_in[0];
    wire wr_trim   = wr_lane0 && hit_trim;
    wire wr_ref    = wr_lane0 && hit_ref;

    wire [TRIM_W-1:0] next_trim   = avs_writedata_in[TRIM_W-1:0];
    wire              next_enable = avs_writedata_in[REF_ENABLE_BIT];
    wire [GAIN_W-1:0] next_gain   = avs_writedata_in[REF_GAIN_LSB +: GAIN_W];

    // Ready is decided by hardware only; no write path reaches it
    wire ready_now = STANDARD_VOLTAGE ? 1'b1 :
                     (reference_enable && ref_stable_sync && (settle_cnt == CNT_ZERO));

    wire [7:0] trim_rd = {2'h0, oscillator_trim};
    wire [7:0] ref_rd  = {reference_ready_flag, reference_enable,
                          4'h0, reference_gain_select};
    wire [DATA_W-1:0] next_rd = hit_trim ? {24'h000000, trim_rd} :
                                hit_ref  ? {24'h000000, ref_rd}  : RD_UNMAPPED;

    otrc_sync2 u_sync
    (
        .mclk_in   (mclk_in),
        .reset_in  (reset_in),
        .clk_en_in (clk_en_in),
        .level_in  (ref_stable_in),
        .level_out (ref_stable_sync)
    );

    otrc_gain_decode u_dec
    (
        .gain_sel_in      (reference_gain_select),
        .enable_in        (reference_enable),
        .level_onehot_out (level_onehot)
    );

    // Bus handshake
    always_ff @(posedge mclk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            answered            <= 1'b0;
            avs_waitrequest_out <= 1'b1;
            avs_readdata_out    <= RD_UNMAPPED;
        end
        else if (clk_en_in)
        begin
            answered            <= access && !answered;
            avs_waitrequest_out <= !(access && !answered);
            avs_readdata_out    <= next_rd;
        end
    end

    // Trim register
    always_ff @(posedge mclk_in or posedge reset_in)
    begin
        if (reset_in)
            oscillator_trim <= TRIM_RESET;
        else if (clk_en_in && wr_trim)
            oscillator_trim <= next_trim;
    end

    // Reference control register
    always_ff @(posedge mclk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            reference_enable      <= EN_RESET;
            reference_gain_select <= GAIN_RESET;
        end
        else if (clk_en_in && wr_ref)
        begin
            reference_enable      <= next_enable;
            reference_gain_select <= next_gain;
        end
    end

    // Settling count after enable
    always_ff @(posedge mclk_in or posedge reset_in)
    begin
        if (reset_in)
            settle_cnt <= SETTLE_CYCLES;
        else if (clk_en_in)
        begin
            if (!reference_enable)
                settle_cnt <= SETTLE_CYCLES;
            else if (settle_cnt != CNT_ZERO)
                settle_cnt <= settle_cnt - 8'h01;
        end
    end

    always_ff @(posedge mclk_in or posedge reset_in)
    begin
        if (reset_in)
            reference_ready_flag <= 1'b0;
        else if (clk_en_in)
            reference_ready_flag <= ready_now;
    end

    // Trim, enable and gain outputs mirror the stored fields in next-value form; level output lags the stored fields by one cycle
    always_ff @(posedge mclk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            oscillator_trim_out       <= TRIM_RESET;
            reference_enable_out      <= EN_RESET;
            reference_gain_select_out <= GAIN_RESET;
            reference_level_out       <= 3'h0;
        end
        else if (clk_en_in)
        begin
            oscillator_trim_out       <= wr_trim ? next_trim : oscillator_trim;
            reference_enable_out      <= wr_ref ? next_enable : reference_enable;
            reference_gain_select_out <= wr_ref ? next_gain : reference_gain_select;
            reference_level_out       <= level_onehot;
        end
    end
endmodule
